// ===== inc/nmt_pkg.sv
// constants and types for the network management slave
package nmt_pkg;
    // ------------------------------------------------------------
    // frame identifiers (function code bases)
    // ------------------------------------------------------------
    localparam logic [10:0] ID_NMT = 11'h000;
    localparam logic [10:0] ID_SYNC = 11'h080;
    localparam logic [10:0] BASE_EMCY = 11'h080;
    localparam logic [10:0] BASE_TPDO1 = 11'h180;
    localparam logic [10:0] BASE_RPDO1 = 11'h200;
    localparam logic [10:0] BASE_TPDO2 = 11'h280;
    localparam logic [10:0] BASE_RPDO2 = 11'h300;
    localparam logic [10:0] BASE_TPDO3 = 11'h380;
    localparam logic [10:0] BASE_RPDO3 = 11'h400;
    localparam logic [10:0] BASE_TPDO4 = 11'h480;
    localparam logic [10:0] BASE_RPDO4 = 11'h500;
    localparam logic [10:0] BASE_SDO_TX = 11'h580;
    localparam logic [10:0] BASE_SDO_RX = 11'h600;
    localparam logic [10:0] BASE_BOOT = 11'h700;
    // ------------------------------------------------------------
    // management frame layout
    // ------------------------------------------------------------
    localparam logic [3:0] NMT_LEN = 4'h2;
    localparam logic [7:0] CMD_START = 8'h01;
    localparam logic [7:0] CMD_STOP = 8'h02;
    localparam logic [7:0] CMD_PREOP = 8'h80;
    localparam logic [7:0] CMD_RST_NODE = 8'h81;
    localparam logic [7:0] CMD_RST_COMM = 8'h82;
    localparam logic [7:0] NODE_ALL = 8'h00;
    localparam logic [6:0] NODE_MIN = 7'h01;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [3:0] INIT_CYCLES = 4'h4;
    localparam logic [3:0] RST_PULSE_CYCLES = 4'h4;
    localparam logic [7:0] STATE_CODE_INIT = 8'h00;
    localparam logic [7:0] STATE_CODE_STOP = 8'h04;
    localparam logic [7:0] STATE_CODE_OPER = 8'h05;
    localparam logic [7:0] STATE_CODE_PREOP = 8'h7F;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_PREOP = 2'b01,
        ST_OPER = 2'b11,
        ST_STOP = 2'b10
    } nmt_state_e;

    typedef enum logic [3:0] {
        SVC_NONE = 4'h0,
        SVC_NMT = 4'h1,
        SVC_SYNC = 4'h2,
        SVC_EMCY = 4'h3,
        SVC_PDO = 4'h4,
        SVC_SDO = 4'h5,
        SVC_BOOT = 4'h6
    } service_e;
endpackage : nmt_pkg

// ===== core/id_classifier.sv
// maps an 11-bit identifier to a service relative to the node id
module id_classifier
    import nmt_pkg::*;
(
    // frame identity
    input wire logic [10:0] can_id,
    input wire logic [6:0] node_id,
    // classification
    output service_e service,
    output logic [1:0] pdo_index,
    output logic pdo_is_tx
);
    logic [10:0] nid;

    always_comb begin
        nid = {4'h0, node_id};
        service = SVC_NONE;
        pdo_index = 2'b00;
        pdo_is_tx = 1'b0;
        if (can_id == ID_NMT) begin
            service = SVC_NMT;
        end else if (can_id == ID_SYNC) begin
            service = SVC_SYNC;
        end else if (can_id == BASE_EMCY + nid) begin
            service = SVC_EMCY;
        end else if (can_id == BASE_RPDO1 + nid) begin // [R3]
            service = SVC_PDO;
            pdo_index = 2'd0;
        end else if (can_id == BASE_RPDO2 + nid) begin // [R3]
            service = SVC_PDO;
            pdo_index = 2'd1;
        end else if (can_id == BASE_RPDO3 + nid) begin // [R3]
            service = SVC_PDO;
            pdo_index = 2'd2;
        end else if (can_id == BASE_RPDO4 + nid) begin // [R3]
            service = SVC_PDO;
            pdo_index = 2'd3;
        end else if (can_id == BASE_TPDO1 + nid || can_id == BASE_TPDO2 + nid ||
                     can_id == BASE_TPDO3 + nid || can_id == BASE_TPDO4 + nid) begin // [R3]
            service = SVC_PDO;
            pdo_is_tx = 1'b1;
            pdo_index = 2'(can_id[9:8] - 2'd1);
        end else if (can_id == BASE_SDO_RX + nid) begin // [R4]
            service = SVC_SDO;
        end else if (can_id == BASE_BOOT + nid) begin
            service = SVC_BOOT;
        end
    end
endmodule : id_classifier

// ===== core/nmt_slave.sv
// network management slave: frame sorting, command decode, state machine
// Overview of operation
// (R1) only standard 11-bit identifiers handled
// (R2) payload values ordered least significant byte first
// (R3) process data at 180..500 plus node
// (R4) service data in 600, out 580 plus node
// (R5) management id zero, two bytes: command, node
// (R6) node identifier lies in 1 to 127
// (R7) decode 01,02,80,81,82 command bytes
// (R8) target zero means broadcast, always execute; the code ignores every command while in init
// (R9) nonzero target executes only on match
// (R10) init only at power-on or reset commands
// (R11) init ends in pre-operational without command
// (R12) node reset whole; comm reset communication only
// (R13) services gated per state
// (R14) stopped: only management commands honoured
// (R15) one management master; device is slave
// (R16) emergency sent on 80 plus node
// (R17) bad length or command silently dropped
module nmt_slave
    import nmt_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // configuration
    input wire logic [6:0] node_id,
    // received frame from the bit-level controller
    input wire logic rx_valid,
    input wire logic rx_ide,
    input wire logic [10:0] rx_id,
    input wire logic [3:0] rx_dlc,
    input wire logic [7:0] rx_byte0,
    input wire logic [7:0] rx_byte1,
    // emergency request from error handling
    input wire logic emcy_req,
    // delivered frames
    output logic pdo_rx_strobe,
    output logic [1:0] pdo_rx_index,
    output logic sdo_rx_strobe,
    output logic sync_strobe,
    // transmit permissions and identifiers
    output logic pdo_tx_enable,
    output logic sdo_tx_enable,
    output logic [10:0] sdo_tx_id,
    output logic emcy_tx_strobe,
    output logic [10:0] emcy_tx_id,
    output logic boot_tx_strobe,
    output logic [10:0] boot_tx_id,
    // state and resets
    output logic [1:0] nmt_state,
    output logic [7:0] state_code,
    output logic node_reset,
    output logic comm_reset,
    output logic node_id_error
);
    // ------------------------------------------------------------
    // identifier classification
    // ------------------------------------------------------------
    service_e svc;
    logic [1:0] pdo_idx;
    logic pdo_tx;
    logic [10:0] nid;

    id_classifier u_class (
        .can_id(rx_id),
        .node_id(node_id),
        .service(svc),
        .pdo_index(pdo_idx),
        .pdo_is_tx(pdo_tx)
    );

    assign nid = {4'h0, node_id};

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic id_ok;
    logic frame_std;
    logic nmt_frame;
    logic cmd_known;
    logic addressed;
    logic cmd_take;

    always_comb begin
        id_ok = (node_id >= NODE_MIN); // [R6]
        frame_std = rx_valid && !rx_ide; // [R1]
        nmt_frame = frame_std && (svc == SVC_NMT) && (rx_dlc == NMT_LEN); // [R5] [R17]
        cmd_known = (rx_byte0 == CMD_START) || (rx_byte0 == CMD_STOP) || (rx_byte0 == CMD_PREOP) ||
                    (rx_byte0 == CMD_RST_NODE) || (rx_byte0 == CMD_RST_COMM); // [R7] [R17]
        addressed = (rx_byte1 == NODE_ALL) // [R8]
                    || (id_ok && rx_byte1 == {1'b0, node_id}); // [R9]
        cmd_take = nmt_frame && cmd_known && addressed;
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    nmt_state_e state;
    nmt_state_e next_state;
    logic [3:0] init_cnt;
    logic [3:0] next_init_cnt;
    logic [3:0] rst_cnt;
    logic [3:0] next_rst_cnt;
    logic rst_is_node;
    logic next_rst_is_node;
    logic boot_due;

    always_comb begin
        next_state = state;
        next_init_cnt = init_cnt;
        next_rst_cnt = (rst_cnt != 4'h0) ? 4'(rst_cnt - 4'h1) : 4'h0;
        next_rst_is_node = rst_is_node;
        boot_due = 1'b0;
        case (state)
            ST_INIT: begin
                if (rst_cnt == 4'h0 && id_ok) begin
                    if (init_cnt == INIT_CYCLES) begin
                        next_state = ST_PREOP; // [R11]
                        boot_due = 1'b1; // [R13]
                        next_init_cnt = 4'h0;
                    end else begin
                        next_init_cnt = 4'(init_cnt + 4'h1);
                    end
                end
            end
            ST_PREOP, ST_OPER, ST_STOP: begin
                if (cmd_take) begin // [R13] [R14]
                    case (rx_byte0)
                        CMD_START: next_state = ST_OPER;
                        CMD_STOP: next_state = ST_STOP;
                        CMD_PREOP: next_state = ST_PREOP;
                        CMD_RST_NODE, CMD_RST_COMM: begin
                            next_state = ST_INIT; // [R10]
                            next_init_cnt = 4'h0;
                            next_rst_cnt = RST_PULSE_CYCLES;
                            next_rst_is_node = (rx_byte0 == CMD_RST_NODE); // [R12]
                        end
                        default: next_state = state;
                    endcase
                end
            end
            default: next_state = ST_INIT;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_INIT; // [R10]
            init_cnt <= 4'h0;
            rst_cnt <= 4'h0;
            rst_is_node <= 1'b0;
        end else begin
            state <= next_state;
            init_cnt <= next_init_cnt;
            rst_cnt <= next_rst_cnt;
            rst_is_node <= next_rst_is_node;
        end
    end

    // ------------------------------------------------------------
    // service gating and outputs
    // ------------------------------------------------------------
    logic is_oper;
    logic is_comm;
    logic [7:0] next_code;
    logic next_pdo_rx;
    logic next_sdo_rx;
    logic next_sync;
    logic next_emcy;

    always_comb begin
        is_oper = (state == ST_OPER);
        is_comm = (state == ST_OPER) || (state == ST_PREOP);
        next_pdo_rx = frame_std && svc == SVC_PDO && !pdo_tx && is_oper; // [R13] [R3] [R2]
        next_sdo_rx = frame_std && svc == SVC_SDO && is_comm; // [R13] [R4] [R2]
        next_sync = frame_std && svc == SVC_SYNC && is_comm; // [R13]
        next_emcy = emcy_req && is_comm; // [R16] [R14]
        case (state)
            ST_INIT: next_code = STATE_CODE_INIT;
            ST_PREOP: next_code = STATE_CODE_PREOP;
            ST_OPER: next_code = STATE_CODE_OPER;
            ST_STOP: next_code = STATE_CODE_STOP;
            default: next_code = STATE_CODE_INIT;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pdo_rx_strobe <= 1'b0;
            pdo_rx_index <= 2'b00;
            sdo_rx_strobe <= 1'b0;
            sync_strobe <= 1'b0;
            pdo_tx_enable <= 1'b0;
            sdo_tx_enable <= 1'b0;
            sdo_tx_id <= 11'h000;
            emcy_tx_strobe <= 1'b0;
            emcy_tx_id <= 11'h000;
            boot_tx_strobe <= 1'b0;
            boot_tx_id <= 11'h000;
            nmt_state <= ST_INIT;
            state_code <= STATE_CODE_INIT;
            node_reset <= 1'b0;
            comm_reset <= 1'b0;
            node_id_error <= 1'b0;
        end else begin
            pdo_rx_strobe <= next_pdo_rx;
            pdo_rx_index <= pdo_idx;
            sdo_rx_strobe <= next_sdo_rx;
            sync_strobe <= next_sync;
            pdo_tx_enable <= (next_state == ST_OPER); // [R13]
            sdo_tx_enable <= (next_state == ST_OPER) || (next_state == ST_PREOP); // [R13] [R14]
            sdo_tx_id <= 11'(BASE_SDO_TX + nid); // [R4]
            emcy_tx_strobe <= next_emcy; // [R16]
            emcy_tx_id <= 11'(BASE_EMCY + nid); // [R16]
            boot_tx_strobe <= boot_due; // [R13]
            boot_tx_id <= 11'(BASE_BOOT + nid);
            nmt_state <= next_state;
            state_code <= next_code;
            node_reset <= (next_rst_cnt != 4'h0) && next_rst_is_node; // [R12]
            comm_reset <= (next_rst_cnt != 4'h0) && !next_rst_is_node; // [R12]
            node_id_error <= !id_ok; // [R6]
        end
    end
endmodule : nmt_slave

// ===== dv/nmt_slave_props.sv
// concurrent checks on the management slave ports
module nmt_slave_props
    import nmt_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // inputs
    input wire logic [6:0] node_id,
    input wire logic rx_valid,
    input wire logic rx_ide,
    input wire logic [10:0] rx_id,
    input wire logic [3:0] rx_dlc,
    input wire logic [7:0] rx_byte0,
    input wire logic [7:0] rx_byte1,
    // outputs
    input wire logic pdo_rx_strobe,
    input wire logic sdo_rx_strobe,
    input wire logic sync_strobe,
    input wire logic pdo_tx_enable,
    input wire logic emcy_tx_strobe,
    input wire logic [10:0] emcy_tx_id,
    input wire logic boot_tx_strobe,
    input wire logic [10:0] boot_tx_id,
    input wire logic [1:0] nmt_state,
    input wire logic node_reset,
    input wire logic comm_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    wire logic nmt_hit = rx_valid && !rx_ide && rx_id == ID_NMT && nmt_state != ST_INIT
        && (rx_byte1 == NODE_ALL || rx_byte1 == {1'b0, node_id});
    pdo_gate_a: assert property (pdo_rx_strobe |-> $past(nmt_state) == ST_OPER)
        else $error("pdo outside operational");
    svc_gate_a: assert property (sdo_rx_strobe || sync_strobe |-> $past(nmt_state) inside {ST_PREOP, ST_OPER})
        else $error("sdo or sync in wrong state");
    ext_drop_a: assert property (rx_valid && rx_ide |=> !(pdo_rx_strobe || sdo_rx_strobe || sync_strobe))
        else $error("extended frame delivered");
    stop_cmd_a: assert property (nmt_hit && rx_dlc == NMT_LEN && rx_byte0 == CMD_STOP |=> nmt_state == ST_STOP)
        else $error("stop not taken");
    bad_len_a: assert property (nmt_hit && rx_dlc != NMT_LEN |=> nmt_state == $past(nmt_state))
        else $error("bad length changed state");
    tx_enable_a: assert property (pdo_tx_enable == (nmt_state == ST_OPER))
        else $error("pdo enable mismatch");
    boot_up_a: assert property (boot_tx_strobe |-> $past(nmt_state) == ST_INIT && nmt_state == ST_PREOP)
        else $error("boot without init exit");
    emcy_id_a: assert property (emcy_tx_strobe |-> emcy_tx_id == BASE_EMCY + 11'(node_id))
        else $error("emergency id wrong");
    init_entry_a: assert property (nmt_state == ST_INIT && $past(nmt_state) != ST_INIT |-> node_reset || comm_reset)
        else $error("init without reset");
    reset_pulse_a: assert property ($rose(node_reset) |-> node_reset [*4] ##1 !node_reset)
        else $error("node reset length");
    cover property (boot_tx_strobe && boot_tx_id == BASE_BOOT + 11'(node_id));
    cover property (pdo_rx_strobe);
    cover property ($rose(comm_reset));
endmodule : nmt_slave_props

bind nmt_slave nmt_slave_props nmt_slave_props_i (.sys_clk, .rstn, .node_id, .rx_valid, .rx_ide, .rx_id, .rx_dlc,
    .rx_byte0, .rx_byte1, .pdo_rx_strobe, .sdo_rx_strobe, .sync_strobe, .pdo_tx_enable, .emcy_tx_strobe,
    .emcy_tx_id, .boot_tx_strobe, .boot_tx_id, .nmt_state, .node_reset, .comm_reset);

// ===== dv/can_master_model.sv
// behavioural management master handing frames to the slave
module can_master_model
    import nmt_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // received frame
    output logic rx_valid,
    output logic rx_ide,
    output logic [10:0] rx_id,
    output logic [3:0] rx_dlc,
    output logic [7:0] rx_byte0,
    output logic [7:0] rx_byte1
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // frame driver, sole master on the bus
    // ------------------------------------------------------------
    initial begin
        {rx_valid, rx_ide, rx_id, rx_dlc, rx_byte0, rx_byte1} = '0;
    end
    // called just after an edge; returns at the taking edge
    task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] b0, input logic [7:0] b1,
        input logic ide);
        rx_valid <= 1'b1;
        rx_ide <= ide;
        rx_id <= id;
        rx_dlc <= dlc;
        rx_byte0 <= b0;
        rx_byte1 <= b1;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        {rx_ide, rx_id, rx_dlc, rx_byte0, rx_byte1} <= ~{ide, id, dlc, b0, b1};
    endtask : send
endmodule : can_master_model

// ===== dv/tb.sv
// self-checking bench for the management slave
module tb
    import nmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic emcy_req = 1'b0;
    logic [6:0] node_id;
    logic rx_valid, rx_ide, pdo_rx_strobe, sdo_rx_strobe, sync_strobe, pdo_tx_enable, sdo_tx_enable;
    logic emcy_tx_strobe, boot_tx_strobe, node_reset, comm_reset, node_id_error, ide, emc;
    logic [1:0] pdo_rx_index, nmt_state, exp_st;
    logic [3:0] rx_dlc, dlc;
    logic [7:0] rx_byte0, rx_byte1, state_code, cmd, tgt;
    logic [10:0] rx_id, sdo_tx_id, emcy_tx_id, boot_tx_id, id;
    logic [31:0] r;
    int errors = 0;
    int n_compared = 0;
    integer seed = 32'h5295;
    logic [15:0] corner [7] = '{16'h0202, 16'h0122, 16'h0113, 16'h0312, 16'h0112, 16'h8112, 16'h8202};
    logic [7:0] cmds [8] = '{8'h01, 8'h02, 8'h80, 8'h81, 8'h82, 8'h03, 8'h00, 8'h01};
    logic [10:0] bases [8] = '{11'h080, 11'h180, 11'h200, 11'h300, 11'h400, 11'h500, 11'h580, 11'h600};
    // ------------------------------------------------------------
    // instances, clock, watchdog
    // ------------------------------------------------------------
    nmt_slave nmt_slave_i (.sys_clk, .rstn, .node_id, .rx_valid, .rx_ide, .rx_id, .rx_dlc, .rx_byte0, .rx_byte1,
        .emcy_req, .pdo_rx_strobe, .pdo_rx_index, .sdo_rx_strobe, .sync_strobe, .pdo_tx_enable, .sdo_tx_enable,
        .sdo_tx_id, .emcy_tx_strobe, .emcy_tx_id, .boot_tx_strobe, .boot_tx_id, .nmt_state, .state_code,
        .node_reset, .comm_reset, .node_id_error);
    can_master_model can_master_model_i (.sys_clk, .rx_valid, .rx_ide, .rx_id, .rx_dlc, .rx_byte0, .rx_byte1);
    always #50 sys_clk = ~sys_clk;
    initial begin
        #3000000;
        errors++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [7:0] tgt_of(input logic [1:0] c);
        return c == 2'h0 ? NODE_ALL : c == 2'h2 ? {1'b0, node_id == 7'h7F ? 7'h01 : node_id + 7'h01} : {1'b0, node_id};
    endfunction : tgt_of
    function automatic logic [1:0] next_st(input logic [1:0] s);
        if (ide || id != ID_NMT || dlc != NMT_LEN || !(tgt == NODE_ALL || tgt == {1'b0, node_id})) return s;
        case (cmd)
            CMD_START: return ST_OPER;
            CMD_STOP: return ST_STOP;
            CMD_PREOP: return ST_PREOP;
            CMD_RST_NODE, CMD_RST_COMM: return ST_INIT;
            default: return s;
        endcase
    endfunction : next_st
    function automatic logic [7:0] code_of(input logic [1:0] s);
        case (s)
            ST_PREOP: return STATE_CODE_PREOP;
            ST_OPER: return STATE_CODE_OPER;
            ST_STOP: return STATE_CODE_STOP;
            default: return STATE_CODE_INIT;
        endcase
    endfunction : code_of
    task automatic wait_boot();
        int n;
        n = 0;
        while (boot_tx_strobe !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(nmt_state, ST_PREOP);
        chk(boot_tx_id, BASE_BOOT + node_id);
        chk(state_code, STATE_CODE_INIT);
        exp_st = ST_PREOP;
    endtask : wait_boot
    task automatic frame();
        logic [1:0] s;
        logic act;
        s = exp_st;
        act = !ide && s inside {ST_PREOP, ST_OPER};
        @(posedge sys_clk);
        emcy_req <= emc;
        can_master_model_i.send(id, dlc, cmd, tgt, ide);
        emcy_req <= 1'b0;
        #1;
        exp_st = next_st(s);
        chk(nmt_state, exp_st);
        chk(state_code, code_of(s));
        chk(sdo_rx_strobe, act && id == BASE_SDO_RX + node_id);
        chk(sync_strobe, act && id == ID_SYNC);
        chk(pdo_rx_strobe, act && s == ST_OPER && 11'(id - node_id) inside {11'h200, 11'h300, 11'h400, 11'h500});
        if (pdo_rx_strobe === 1'b1) chk(pdo_rx_index, 11'(id - node_id - BASE_RPDO1) >> 8);
        chk(emcy_tx_strobe, emc && s inside {ST_PREOP, ST_OPER});
        chk(pdo_tx_enable, exp_st == ST_OPER);
        chk(sdo_tx_enable, exp_st inside {ST_PREOP, ST_OPER});
        if (exp_st == ST_INIT) begin
            chk({node_reset, comm_reset}, {cmd == CMD_RST_NODE, cmd == CMD_RST_COMM});
            wait_boot();
        end
    endtask : frame
    task report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        node_id <= 7'($unsigned($random(seed)) % 127 + 1);
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        wait_boot();
        chk(node_id_error, 0);
        chk(sdo_tx_id, BASE_SDO_TX + node_id);
        $display("test boot done");
        {id, ide, emc} = '0;
        for (int k = 0; k < 7; k++) begin
            cmd = corner[k][15:8];
            tgt = tgt_of(corner[k][5:4]);
            dlc = corner[k][3:0];
            frame();
        end
        $display("test corner done");
        for (int k = 0; k < 400; k++) begin
            r = $random(seed);
            {emc, ide, cmd, tgt} = {r[0], r[3:1] == 3'h0, cmds[r[10:8]], tgt_of(r[5:4])};
            dlc = r[13:11] == 3'h0 ? 4'h3 : NMT_LEN;
            id = r[16:14] < 3'h3 ? ID_NMT : r[20] ? ID_SYNC : bases[r[19:17]] + node_id;
            frame();
        end
        $display("test random done");
        @(posedge sys_clk);
        node_id <= 7'h00;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(node_id_error, 1);
        $display("test node id done");
        report_and_stop();
    end
endmodule : tb
